//--- rtl/aacl_pkg.sv
// Package: register map, field positions, reset values and timing for the alert block
package aacl_pkg;
  // Pointer values
  localparam logic [2:0] PTR_RESULT = 3'h0;
  localparam logic [2:0] PTR_STATUS = 3'h1;
  localparam logic [2:0] PTR_CONFIG = 3'h2;
  localparam logic [2:0] PTR_UNDER = 3'h3;
  localparam logic [2:0] PTR_OVER = 3'h4;
  // Configuration field positions
  localparam int CFG_CYCLE_MSB = 7;
  localparam int CFG_CYCLE_LSB = 5;
  localparam int CFG_HOLD = 4;
  localparam int CFG_FLAG_EN = 3;
  localparam int CFG_PIN_EN = 2;
  localparam int CFG_RSVD = 1;
  localparam int CFG_POL = 0;
  // Status field positions
  localparam int STS_OVER = 1;
  localparam int STS_UNDER = 0;
  // Ten-bit value field in a sixteen-bit word
  localparam int VAL_MSB = 11;
  localparam int VAL_LSB = 2;
  localparam int WORD_FLAG = 15;
  localparam logic [15:0] LIMIT_MASK = 16'h0ffc;
  // Reset values
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [15:0] UNDER_RESET = 16'h0000;
  localparam logic [15:0] OVER_RESET = 16'h0fff;
  // Timing: single conversion time and clock rate
  localparam int SINGLE_CONVERSION_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int CONV_CYCLES = (SINGLE_CONVERSION_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Smallest interval factor is 32, i.e. a shift of 5 for code 001
  localparam int CYCLE_SHIFT_BASE = 4;

  // Configuration register fields
  typedef struct packed {
    logic [2:0] cycle_time;
    logic hold;
    logic flag_en;
    logic pin_en;
    logic rsvd;
    logic polarity;
  } aacl_cfg_t;
endpackage : aacl_pkg

//--- rtl/aacl_top.sv
// Alert configuration, limit registers, limit comparison and auto-conversion timer
// Operation
// - Cycle code zero keeps automatic mode off
// - Non-zero cycle code starts repeated conversions
// - Interval is conversion time times 32..2048
// - Hold clear: flags self-clear past hysteresis
// - Hold set: flags clear only by write-one
// - Flag-enable gates bit 15 of result
// - Pin-enable zero floats alert, one drives
// - Polarity zero active low, one high
// - No alert pin: enable, polarity ignored
// - Config bit 1 reads zero, write zero
// - Config at pointer 02h, resets 00h
// - Under limit at 03h, bits 11:2, 0000h
// - Result below under limit raises alert
// - Over limit at 04h, bits 11:2, 0ffch
// - Result above over limit raises alert
// - Limit reserved bits read zero, write zero
// - Status: over bit 1, under bit 0, write-one-clear
// - Bit 15 high when enabled and flag set
// - Hysteresis margin comes from the release_margin input
`timescale 1ns/100ps
`default_nettype none

module aacl_top #(
  parameter int CONV_CYCLES = aacl_pkg::CONV_CYCLES,
  parameter bit HAS_ALERT_PIN = 1'b1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [2:0] reg_ptr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic result_valid,
  input wire logic [9:0] result_value,
  input wire logic [9:0] release_margin,
  output logic conv_start,
  output logic alert_o,
  output logic alert_oe_n,
  output logic [1:0] status_flags,
  output logic auto_mode
);

  // Worst interval is CONV_CYCLES * 2048; 24 bits hold that for any sane rate
  localparam int TW = 24;

  aacl_pkg::aacl_cfg_t cfg_reg;
  logic [9:0] under_reg;
  logic [9:0] over_reg;
  logic [9:0] result_reg;
  logic over_reg_flag;
  logic under_reg_flag;
  logic [TW-1:0] timer_reg;
  logic [15:0] rdata_reg;
  logic conv_reg;
  logic alert_reg;
  logic oe_n_reg;
  logic auto_reg;

  // Interval in clock cycles for a non-zero cycle code
  function automatic logic [TW-1:0] interval_cycles(input logic [2:0] code);
    logic [TW-1:0] base;
    base = TW'(CONV_CYCLES);
    interval_cycles = base << (TW'(code) + TW'(aacl_pkg::CYCLE_SHIFT_BASE));
  endfunction : interval_cycles

  // Take the ten-bit value field out of a sixteen-bit word
  function automatic logic [9:0] word_value(input logic [15:0] w);
    word_value = w[aacl_pkg::VAL_MSB:aacl_pkg::VAL_LSB];
  endfunction : word_value

  // Place a ten-bit value into the value field, other bits zero
  function automatic logic [15:0] value_word(input logic [9:0] v);
    value_word = {4'h0, v, 2'h0};
  endfunction : value_word

  // Access decode
  wire logic wr_cfg = ce & reg_wr & (reg_ptr == aacl_pkg::PTR_CONFIG);
  wire logic wr_under = ce & reg_wr & (reg_ptr == aacl_pkg::PTR_UNDER);
  wire logic wr_over = ce & reg_wr & (reg_ptr == aacl_pkg::PTR_OVER);
  wire logic wr_sts = ce & reg_wr & (reg_ptr == aacl_pkg::PTR_STATUS);
  wire logic rd_result = ce & reg_rd & (reg_ptr == aacl_pkg::PTR_RESULT);

  // Config write with the reserved bit forced low
  wire aacl_pkg::aacl_cfg_t cfg_next = aacl_pkg::aacl_cfg_t'(reg_wdata[7:0] &
    ~(8'h01 << aacl_pkg::CFG_RSVD));

  // Limit comparisons, unsigned and strict; sums kept at 11 bits so no wrap
  wire logic [10:0] over_release_sum = {1'b0, result_value} + {1'b0, release_margin};
  wire logic [10:0] under_release_sum = {1'b0, under_reg} + {1'b0, release_margin};
  wire logic over_hit = result_valid & (result_value > over_reg);
  wire logic under_hit = result_valid & (result_value < under_reg);
  wire logic over_back = result_valid & ~cfg_reg.hold &
    (over_release_sum < {1'b0, over_reg});
  wire logic under_back = result_valid & ~cfg_reg.hold &
    ({1'b0, result_value} > under_release_sum);
  wire logic over_w1c = wr_sts & reg_wdata[aacl_pkg::STS_OVER];
  wire logic under_w1c = wr_sts & reg_wdata[aacl_pkg::STS_UNDER];

  // Set wins over every kind of clear so a fresh violation is never lost
  wire logic over_next = over_hit | (over_reg_flag & ~over_back & ~over_w1c);
  wire logic under_next = under_hit | (under_reg_flag & ~under_back & ~under_w1c);
  wire logic any_flag_next = over_next | under_next;

  // Auto timer: reload when expired; counting stops while the code is zero
  // A non-zero code changed mid-count applies at the next reload; the running interval ends first
  wire logic auto_on = (cfg_reg.cycle_time != 3'h0);
  wire logic timer_hit = auto_on & (timer_reg == '0);
  wire logic [TW-1:0] timer_next = !auto_on ? '0 :
    timer_hit ? interval_cycles(cfg_reg.cycle_time) - TW'(1) :
    timer_reg - TW'(1);

  // Alert pin level and drive; a variant without the pin ignores both bits
  wire logic pin_drive = HAS_ALERT_PIN & cfg_reg.pin_en;
  wire logic alert_level = HAS_ALERT_PIN &
    (cfg_reg.polarity ? any_flag_next : ~any_flag_next);

  // Result word as read, with bit 15 gated by the flag enable
  wire logic [15:0] result_word = value_word(result_reg) |
    (16'(cfg_reg.flag_en & (over_reg_flag | under_reg_flag)) << aacl_pkg::WORD_FLAG);
  wire logic [15:0] rdata_next =
    (reg_ptr == aacl_pkg::PTR_RESULT) ? result_word :
    (reg_ptr == aacl_pkg::PTR_STATUS) ? {14'h0000, over_reg_flag, under_reg_flag} :
    (reg_ptr == aacl_pkg::PTR_CONFIG) ? {8'h00, cfg_reg} :
    (reg_ptr == aacl_pkg::PTR_UNDER) ? value_word(under_reg) :
    (reg_ptr == aacl_pkg::PTR_OVER) ? value_word(over_reg) :
    16'h0000;

  // Configuration and limit registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_reg <= aacl_pkg::aacl_cfg_t'(aacl_pkg::CONFIG_RESET);
      auto_reg <= (aacl_pkg::CONFIG_RESET[aacl_pkg::CFG_CYCLE_MSB:aacl_pkg::CFG_CYCLE_LSB]
        != 3'h0);
      under_reg <= word_value(aacl_pkg::UNDER_RESET);
      over_reg <= word_value(aacl_pkg::OVER_RESET);
    end else begin
      if (wr_cfg) cfg_reg <= cfg_next;
      // Mirror of the cycle code so auto_mode leaves straight from a flop
      if (wr_cfg) auto_reg <= (cfg_next.cycle_time != 3'h0);
      if (wr_under) under_reg <= word_value(reg_wdata & aacl_pkg::LIMIT_MASK);
      if (wr_over) over_reg <= word_value(reg_wdata & aacl_pkg::LIMIT_MASK);
    end
  end

  // Latest result and alert flags
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      result_reg <= 10'h000;
      over_reg_flag <= 1'b0;
      under_reg_flag <= 1'b0;
    end else if (ce) begin
      if (result_valid) result_reg <= result_value;
      over_reg_flag <= over_next;
      under_reg_flag <= under_next;
    end
  end

  // Timer, read data and pin outputs, all straight from flops
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      timer_reg <= '0;
      conv_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      alert_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end else if (ce) begin
      timer_reg <= timer_next;
      // A result read also kicks a conversion, as in normal mode
      conv_reg <= timer_hit | rd_result;
      if (reg_rd) rdata_reg <= rdata_next;
      alert_reg <= alert_level;
      oe_n_reg <= ~pin_drive;
    end
  end

  assign reg_rdata = rdata_reg;
  assign conv_start = conv_reg;
  assign alert_o = alert_reg;
  assign alert_oe_n = oe_n_reg;
  assign status_flags = {over_reg_flag, under_reg_flag};
  assign auto_mode = auto_reg;

  // Checks: auto timer
  chk_auto_off_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    ce && !auto_on && !rd_result |=> !conv_start)
    else $error("conversion started with auto mode off");

  chk_timer_idle: assert property (@(posedge clk_sys) disable iff (rst)
    ce && !auto_on |=> timer_reg == '0)
    else $error("timer ran with auto mode off");

  chk_auto_mode_out: assert property (@(posedge clk_sys) disable iff (rst)
    auto_mode == (cfg_reg.cycle_time != 3'h0))
    else $error("auto mode output disagrees with cycle code");

  chk_auto_first_kick: assert property (@(posedge clk_sys) disable iff (rst)
    ce && $rose(auto_on) && timer_reg == '0 |=> conv_start)
    else $error("auto mode did not start");

  chk_interval_reload: assert property (@(posedge clk_sys) disable iff (rst)
    ce && timer_hit && !wr_cfg |=> timer_reg == interval_cycles(cfg_reg.cycle_time) - TW'(1))
    else $error("wrong conversion interval");

  // Checks: limit flags; they only move on a result or a status write
  chk_over_set: assert property (@(posedge clk_sys) disable iff (rst)
    ce && result_valid && result_value > over_reg |=> over_reg_flag)
    else $error("over flag not raised");

  chk_under_set: assert property (@(posedge clk_sys) disable iff (rst)
    ce && result_valid && result_value < under_reg |=> under_reg_flag)
    else $error("under flag not raised");

  chk_self_release: assert property (@(posedge clk_sys) disable iff (rst)
    ce && under_reg_flag && under_back && !under_hit |=> !under_reg_flag)
    else $error("under flag did not self-clear");

  chk_over_release: assert property (@(posedge clk_sys) disable iff (rst)
    ce && over_reg_flag && over_back && !over_hit |=> !over_reg_flag)
    else $error("over flag did not self-clear");

  chk_over_stays: assert property (@(posedge clk_sys) disable iff (rst)
    ce && over_reg_flag && !result_valid && !over_w1c |=> over_reg_flag)
    else $error("over flag cleared without cause");

  chk_under_stays: assert property (@(posedge clk_sys) disable iff (rst)
    ce && under_reg_flag && !result_valid && !under_w1c |=> under_reg_flag)
    else $error("under flag cleared without cause");

  chk_hold_sticky: assert property (@(posedge clk_sys) disable iff (rst)
    ce && cfg_reg.hold && over_reg_flag && !over_w1c |=> over_reg_flag)
    else $error("held over flag cleared itself");

  chk_hold_under_sticky: assert property (@(posedge clk_sys) disable iff (rst)
    ce && cfg_reg.hold && under_reg_flag && !under_w1c |=> under_reg_flag)
    else $error("held under flag cleared itself");

  chk_hold_no_release: assert property (@(posedge clk_sys) disable iff (rst)
    ce && cfg_reg.hold |-> !over_back && !under_back)
    else $error("release allowed while held");

  chk_w1c_clear: assert property (@(posedge clk_sys) disable iff (rst)
    ce && over_w1c && !over_hit |=> !over_reg_flag)
    else $error("write-one did not clear over flag");

  chk_under_w1c: assert property (@(posedge clk_sys) disable iff (rst)
    ce && under_w1c && !under_hit |=> !under_reg_flag)
    else $error("write-one did not clear under flag");

  // Checks: register writes and reads
  chk_cfg_write: assert property (@(posedge clk_sys) disable iff (rst)
    wr_cfg |=> 8'(cfg_reg) == ($past(reg_wdata[7:0]) & 8'hfd))
    else $error("config write lost");

  chk_cfg_rsvd_zero: assert property (@(posedge clk_sys) disable iff (rst)
    !cfg_reg.rsvd)
    else $error("reserved config bit set");

  chk_cfg_read: assert property (@(posedge clk_sys) disable iff (rst)
    ce && reg_rd && reg_ptr == aacl_pkg::PTR_CONFIG |=> (reg_rdata & 16'hff02) == 16'h0000)
    else $error("config reserved bits read non-zero");

  chk_under_write: assert property (@(posedge clk_sys) disable iff (rst)
    wr_under |=>
      under_reg == $past(reg_wdata[aacl_pkg::VAL_MSB:aacl_pkg::VAL_LSB]))
    else $error("under limit write lost");

  chk_over_write: assert property (@(posedge clk_sys) disable iff (rst)
    wr_over |=>
      over_reg == $past(reg_wdata[aacl_pkg::VAL_MSB:aacl_pkg::VAL_LSB]))
    else $error("over limit write lost");

  chk_limit_rsvd: assert property (@(posedge clk_sys) disable iff (rst)
    ce && reg_rd && (reg_ptr == aacl_pkg::PTR_UNDER || reg_ptr == aacl_pkg::PTR_OVER) |=>
      (reg_rdata & ~aacl_pkg::LIMIT_MASK) == 16'h0000)
    else $error("limit reserved bits not zero");

  chk_status_read: assert property (@(posedge clk_sys) disable iff (rst)
    ce && reg_rd && reg_ptr == aacl_pkg::PTR_STATUS |=>
      reg_rdata == {14'h0000, $past(over_reg_flag), $past(under_reg_flag)})
    else $error("status read wrong");

  chk_unmapped_read: assert property (@(posedge clk_sys) disable iff (rst)
    ce && reg_rd && reg_ptr > aacl_pkg::PTR_OVER |=> reg_rdata == 16'h0000)
    else $error("pointer outside this block read non-zero");

  chk_flag_bit_read: assert property (@(posedge clk_sys) disable iff (rst)
    ce && reg_rd && reg_ptr == aacl_pkg::PTR_RESULT |=>
      reg_rdata[15] == ($past(cfg_reg.flag_en) && $past(over_reg_flag || under_reg_flag)))
    else $error("result bit 15 wrong");

  // Checks: alert pin
  chk_pin_float: assert property (@(posedge clk_sys) disable iff (rst)
    ce && !pin_drive |=> alert_oe_n)
    else $error("alert driven while disabled");

  chk_pin_driven: assert property (@(posedge clk_sys) disable iff (rst)
    ce && pin_drive |=> !alert_oe_n)
    else $error("alert not driven while enabled");

  chk_no_pin_idle: assert property (@(posedge clk_sys) disable iff (rst)
    !HAS_ALERT_PIN |-> alert_oe_n && !alert_o)
    else $error("variant without pin moved the alert");

  chk_alert_level: assert property (@(posedge clk_sys) disable iff (rst)
    ce && HAS_ALERT_PIN |=> alert_o == (cfg_reg.polarity == (over_reg_flag | under_reg_flag))
      || $past(wr_cfg))
    else $error("alert level wrong");

endmodule : aacl_top

`default_nettype wire

//--- sim/aacl_conv_model.sv
// Conversion core stand-in that answers each start pulse taken while idle with a result
`timescale 1ns/100ps
`default_nettype none
module aacl_conv_model #(
  parameter int LAT = 3
) (
  input wire logic clk_sys,
  input wire logic conv_start,
  input wire logic [9:0] sample,
  output logic result_valid,
  output logic [9:0] result_value
);
  int cnt = 0;
  initial begin
    result_valid = 1'b0;
    result_value = 10'h000;
  end
  // A start while busy is absorbed; the value is only good under the strobe
  always @(posedge clk_sys) begin
    result_valid <= 1'b0;
    result_value <= ~result_value;
    if (conv_start && cnt == 0) cnt <= LAT;
    else if (cnt == 1) begin
      result_valid <= 1'b1;
      result_value <= sample;
      cnt <= 0;
    end else if (cnt > 1) cnt <= cnt - 1;
  end
endmodule : aacl_conv_model
`default_nettype wire

//--- sim/aacl_top_test.sv
// Self-checking bench for the alert configuration and limit block
`timescale 1ns/100ps
`default_nettype none
module aacl_top_test;
  localparam int CC = 2;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] reg_ptr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [9:0] release_margin = 10'h004;
  logic [9:0] sample = 10'h000;
  logic [15:0] reg_rdata;
  logic result_valid, conv_start, alert_o, alert_oe_n, auto_mode;
  logic [9:0] result_value;
  logic [1:0] status_flags;
  logic [31:0] exp_q[$];
  logic [31:0] w;
  logic rd_seen = 1'b0;
  int n_errors = 0;
  int checked = 0;
  int k, c, gap;
  always #12.5 clk_sys = ~clk_sys;
  aacl_top #(.CONV_CYCLES(CC)) aacl_top_i (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_ptr(reg_ptr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .result_valid(result_valid), .result_value(result_value),
    .release_margin(release_margin), .conv_start(conv_start), .alert_o(alert_o),
    .alert_oe_n(alert_oe_n), .status_flags(status_flags), .auto_mode(auto_mode));
  aacl_conv_model aacl_conv_model_i (.clk_sys(clk_sys), .conv_start(conv_start),
    .sample(sample), .result_valid(result_valid), .result_value(result_value));
  task automatic give_verdict();
    $display("counts: %0d compared, %0d mismatched", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // Register access; a read leaves its masked expectation for the watcher
  task automatic acc(input logic wt, input logic [2:0] p, input logic [15:0] d,
    input logic [15:0] m);
    if (!wt) exp_q.push_back({m, d});
    reg_ptr = p;
    reg_wdata = d;
    reg_wr = wt;
    reg_rd = !wt;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // One idle edge so the next call never raises a strobe in this same step
    @(negedge clk_sys);
  endtask : acc
  // Reading the result word kicks a conversion; wait for its answer
  task automatic convert(input logic [9:0] v);
    sample = v;
    acc(1'b0, aacl_pkg::PTR_RESULT, 16'h0000, 16'h0000);
    for (k = 0; k < 20 && result_valid !== 1'b1; k++) @(negedge clk_sys);
    if (result_valid !== 1'b1) begin
      n_errors++;
      give_verdict();
    end
    @(negedge clk_sys);
  endtask : convert
  // Read data is settled by the falling edge after the taking edge
  always @(posedge clk_sys) rd_seen <= reg_rd & ~rst;
  always @(negedge clk_sys) begin
    if (rd_seen) begin
      w = exp_q.pop_front();
      cmp(reg_rdata & w[31:16], w[15:0]);
    end
  end
  initial begin
    c = $urandom(68);
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    acc(1'b0, aacl_pkg::PTR_CONFIG, 16'h0000, 16'hffff);
    acc(1'b0, aacl_pkg::PTR_UNDER, 16'h0000, 16'hffff);
    acc(1'b0, aacl_pkg::PTR_OVER, 16'h0ffc, 16'hffff);
    acc(1'b1, aacl_pkg::PTR_CONFIG, 16'h00fd, 16'h0000);
    acc(1'b0, aacl_pkg::PTR_CONFIG, 16'h00fd, 16'hffff);
    cmp({15'h0, auto_mode}, 16'h0001);
    acc(1'b1, aacl_pkg::PTR_UNDER, 16'h0ffc, 16'h0000);
    acc(1'b0, aacl_pkg::PTR_UNDER, 16'h0ffc, 16'hffff);
    acc(1'b1, aacl_pkg::PTR_UNDER, 16'h0080, 16'h0000);
    acc(1'b1, aacl_pkg::PTR_OVER, 16'h0400, 16'h0000);
    acc(1'b1, aacl_pkg::PTR_CONFIG, 16'h000d, 16'h0000);
    cmp({15'h0, auto_mode}, 16'h0000);
    $display("test registers done");
    convert(10'h100);
    cmp({14'h0, status_flags}, 16'h0000);
    convert(10'h101);
    cmp({14'h0, status_flags}, 16'h0002);
    cmp({14'h0, alert_oe_n, alert_o}, 16'h0001);
    acc(1'b0, aacl_pkg::PTR_RESULT, 16'h8404, 16'hffff);
    acc(1'b1, aacl_pkg::PTR_CONFIG, 16'h000c, 16'h0000);
    @(negedge clk_sys);
    cmp({14'h0, alert_oe_n, alert_o}, 16'h0000);
    acc(1'b1, aacl_pkg::PTR_CONFIG, 16'h0000, 16'h0000);
    acc(1'b0, aacl_pkg::PTR_RESULT, 16'h0000, 16'h8000);
    cmp({15'h0, alert_oe_n}, 16'h0001);
    acc(1'b1, aacl_pkg::PTR_CONFIG, 16'h000d, 16'h0000);
    convert(10'h0fc);
    cmp({14'h0, status_flags}, 16'h0002);
    convert(10'h0fb);
    cmp({14'h0, status_flags}, 16'h0000);
    cmp({14'h0, alert_oe_n, alert_o}, 16'h0000);
    $display("test over range done");
    acc(1'b1, aacl_pkg::PTR_CONFIG, 16'h001d, 16'h0000);
    convert(10'($urandom_range(0, 31)));
    cmp({14'h0, status_flags}, 16'h0001);
    convert(10'h080);
    cmp({14'h0, status_flags}, 16'h0001);
    acc(1'b1, aacl_pkg::PTR_STATUS, 16'h0001, 16'h0000);
    cmp({14'h0, status_flags}, 16'h0000);
    $display("test hold done");
    // Clock enable low: a config write must leave no trace
    ce = 1'b0;
    acc(1'b1, aacl_pkg::PTR_CONFIG, 16'h0020, 16'h0000);
    ce = 1'b1;
    acc(1'b0, aacl_pkg::PTR_CONFIG, 16'h001d, 16'hffff);
    // Interval per cycle code, measured between two start pulses
    for (c = 1; c < 8; c++) begin
      acc(1'b1, aacl_pkg::PTR_CONFIG, {8'h00, c[2:0], 5'h0d}, 16'h0000);
      for (k = 0; k < 5000 && conv_start !== 1'b1; k++) @(negedge clk_sys);
      if (conv_start !== 1'b1) begin
        n_errors++;
        give_verdict();
      end
      @(negedge clk_sys);
      for (gap = 1; gap < 5000 && conv_start !== 1'b1; gap++) @(negedge clk_sys);
      cmp(gap[15:0], 16'(CC << (c + 4)));
      if (conv_start !== 1'b1) give_verdict();
    end
    acc(1'b1, aacl_pkg::PTR_CONFIG, 16'h000d, 16'h0000);
    for (gap = 0; gap < 300 && conv_start !== 1'b1; gap++) @(negedge clk_sys);
    cmp(gap[15:0], 16'd300);
    $display("test timer done");
    give_verdict();
  end
endmodule : aacl_top_test
`default_nettype wire
